/* File: src/bhec_core.sv */
`timescale 1ns/1ns
module bhec_core #(
	parameter int W = bhec_pkg::SAMPLE_W
) (
	input  wire logic                        clk,
	input  wire logic                        reset,
	input  wire logic [bhec_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [bhec_pkg::DATA_W-1:0] reg_wdata,
	input  wire logic                        reg_write,
	input  wire logic                        reg_read,
	output logic      [bhec_pkg::DATA_W-1:0] reg_rdata,
	input  wire logic                        sda_in,
	input  wire logic                        scl_in,
	input  wire logic        [W-1:0]         in_left,
	input  wire logic        [W-1:0]         in_right,
	input  wire logic                        in_valid,
	output logic                             in_ready,
	output logic             [W-1:0]         out_left,
	output logic             [W-1:0]         out_right,
	output logic             [W-1:0]         out_sub,
	output logic                             out_valid,
	input  wire logic                        out_ready
);
	import bhec_pkg::*;

	localparam int XW = W + 2;
	localparam int PW = XW + INTENS_W + 1;
	localparam int IW = XW + DECIM_W + 2;

	function automatic logic [W-1:0] sat(input logic signed [XW:0] v);
		logic signed [XW:0] hi;
		logic signed [XW:0] lo;
		hi = (XW+1)'((1 <<< (W - 1)) - 1);
		lo = -hi - (XW+1)'(1);
		if (v > hi) begin
			sat = hi[W-1:0];
		end else if (v < lo) begin
			sat = lo[W-1:0];
		end else begin
			sat = v[W-1:0];
		end
	endfunction

	logic                 reset_d_reg;
	logic                 sda_meta_reg;
	logic                 sda_sync_reg;
	logic                 scl_meta_reg;
	logic                 scl_sync_reg;
	logic [INTENS_W-1:0]  intensity_reg;
	logic [DIVN_W-1:0]    div_n_reg;
	logic                 sub_en_reg;
	logic                 fx_off_reg;
	logic [DATA_W-1:0]    rdata_reg;
	logic [DATA_W-1:0]    rdata_next;
	logic [DIVCNT_W-1:0]  div_cnt_reg;
	logic [DIVN_W-1:0]    div_rep_reg;
	logic [DECIM_W-1:0]   dec_cnt_reg;
	logic signed [XW-1:0] lpf_reg;
	logic signed [XW-1:0] sub_reg;
	logic signed [XW-1:0] dec_s1_reg;
	logic signed [XW-1:0] env_reg;
	logic signed [XW-1:0] harm_s2_reg;
	logic signed [XW-1:0] harm_s3_reg;
	logic signed [XW-1:0] interp_prev_reg;

	wire                  release_edge;
	wire [INTENS_W-1:0]   strap_level;
	wire                  conv_tick;
	wire                  fifo_ready;
	wire                  take;
	wire                  dsp_tick;
	wire                  wr_sel_ctrl;
	wire                  wr_sel_int;
	wire                  wr_sel_div;
	wire [DIVN_W-1:0]     wr_div_val;
	wire                  wr_div_ok;
	wire signed [XW-1:0]  left_x;
	wire signed [XW-1:0]  right_x;
	wire signed [XW-1:0]  mono;
	wire signed [XW-1:0]  lpf_step;
	wire signed [XW-1:0]  sub_step;
	wire signed [XW-1:0]  rect;
	wire signed [XW-1:0]  env_step;
	wire signed [XW-1:0]  harm_next;
	wire signed [PW-1:0]  scaled_prod;
	wire signed [PW-1:0]  scaled_next;
	wire signed [XW-1:0]  scaled_cut;
	wire signed [IW-1:0]  interp_diff;
	wire signed [IW-1:0]  interp_ramp;
	wire signed [XW:0]    interp;
	wire signed [XW:0]    low_half;
	wire signed [XW:0]    mix_left;
	wire signed [XW:0]    mix_right;
	wire [W-1:0]          wr_left;
	wire [W-1:0]          wr_right;
	wire [W-1:0]          wr_sub;

	// Pin straps come from another domain; only the second stage is read by logic.
	always_ff @(posedge clk) begin
		sda_meta_reg <= sda_in;
		sda_sync_reg <= sda_meta_reg;
		scl_meta_reg <= scl_in;
		scl_sync_reg <= scl_meta_reg;
	end

	assign release_edge = reset_d_reg && !reset;
	assign strap_level  = (sda_sync_reg && !scl_sync_reg) ? INTENS_3Q :
	                      (!sda_sync_reg && scl_sync_reg) ? INTENS_HALF : INTENS_FULL;

	assign wr_sel_ctrl = reg_write && (reg_addr == REG_CTRL);
	assign wr_sel_int  = reg_write && (reg_addr == REG_INTENSITY);
	assign wr_sel_div  = reg_write && (reg_addr == REG_DIVIDER);
	assign wr_div_val  = reg_wdata[DIVN_LSB +: DIVN_W];
	// Values outside the legal range are dropped so the rate chain never divides by zero.
	assign wr_div_ok   = (wr_div_val >= DIVN_MIN) && (wr_div_val <= DIVN_MAX);

	always_ff @(posedge clk) begin
		if (reset) begin
			reset_d_reg   <= 1'b1;
			intensity_reg <= INTENS_FULL;
			div_n_reg     <= DIVN_RESET;
			sub_en_reg    <= 1'b0;
			fx_off_reg    <= 1'b0;
			rdata_reg     <= '0;
		end else begin
			reset_d_reg <= 1'b0;
			rdata_reg   <= reg_read ? rdata_next : '0;
			if (release_edge) begin
				intensity_reg <= strap_level;
			end else if (wr_sel_int) begin
				intensity_reg <= reg_wdata[INTENS_LSB +: INTENS_W];
			end
			if (wr_sel_div && wr_div_ok) begin
				div_n_reg <= wr_div_val;
			end
			if (wr_sel_ctrl) begin
				sub_en_reg <= reg_wdata[CTRL_SUB_BIT];
				fx_off_reg <= reg_wdata[CTRL_OFF_BIT];
			end
		end
	end

	assign rdata_next = (reg_addr == REG_CTRL) ?
	                    DATA_W'({fx_off_reg, 3'h0, sub_en_reg, 3'h0}) :
	                    (reg_addr == REG_INTENSITY) ? DATA_W'({intensity_reg, 2'h0}) :
	                    (reg_addr == REG_DIVIDER) ? DATA_W'({div_n_reg, 4'h0}) :
	                    (reg_addr == REG_STATUS) ? DATA_W'({dec_cnt_reg, out_valid, fifo_ready}) : '0;
	assign reg_rdata  = rdata_reg;

	// One converter sample slot every n x 256 clocks; the corner sits at 1/400 of that rate.
	always_ff @(posedge clk) begin
		if (reset) begin
			div_cnt_reg <= '0;
			div_rep_reg <= '0;
		end else if (div_cnt_reg != DIVCNT_CONV) begin
			div_cnt_reg <= div_cnt_reg + DIVCNT_W'(1);
		end else begin
			div_cnt_reg <= '0;
			div_rep_reg <= (div_rep_reg + DIVN_W'(1) >= div_n_reg) ? '0 : div_rep_reg + DIVN_W'(1);
		end
	end

	assign conv_tick = (div_cnt_reg == DIVCNT_CONV) && (div_rep_reg + DIVN_W'(1) >= div_n_reg);
	assign in_ready  = conv_tick && fifo_ready;
	assign take      = in_ready && in_valid;
	assign dsp_tick  = take && (dec_cnt_reg == DECIM_LAST);

	assign left_x   = XW'(signed'(in_left));
	assign right_x  = XW'(signed'(in_right));
	assign mono     = left_x + right_x;
	assign lpf_step = (mono - lpf_reg) >>> LP_SHIFT;
	assign sub_step = (mono - sub_reg) >>> SUB_SHIFT;

	// Full-wave rectification creates the harmonic series; the envelope removes its offset.
	assign rect      = dec_s1_reg[XW-1] ? -dec_s1_reg : dec_s1_reg;
	assign env_step  = (rect - env_reg) >>> ENV_SHIFT;
	assign harm_next = rect - env_reg;

	assign scaled_prod = PW'(harm_s2_reg) * PW'(signed'({1'b0, intensity_reg}));
	// A signed divisor keeps negative harmonics from being divided as large unsigned numbers.
	assign scaled_next = scaled_prod / signed'(PW'(INTENS_FULL));
	assign scaled_cut  = scaled_next[XW-1:0];

	// Linear ramp from the previous to the newest harmonic sample across one decimation frame.
	assign interp_diff = IW'(harm_s3_reg) - IW'(interp_prev_reg);
	assign interp_ramp = (interp_diff * IW'(signed'({1'b0, dec_cnt_reg}))) >>> DECIM_W;
	assign interp      = (XW+1)'(interp_prev_reg) + (XW+1)'(interp_ramp);

	assign low_half  = (XW+1)'(lpf_reg >>> 1);
	assign mix_left  = (XW+1)'(left_x) - low_half + interp;
	assign mix_right = (XW+1)'(right_x) - low_half + interp;
	assign wr_left   = fx_off_reg ? in_left : sat(mix_left);
	assign wr_right  = fx_off_reg ? in_right : sat(mix_right);
	assign wr_sub    = sub_en_reg ? sat((XW+1)'(sub_reg >>> 1)) : '0;

	always_ff @(posedge clk) begin
		if (reset) begin
			dec_cnt_reg <= '0;
			lpf_reg     <= '0;
			sub_reg     <= '0;
		end else if (take) begin
			dec_cnt_reg <= dec_cnt_reg + DECIM_W'(1);
			lpf_reg     <= lpf_reg + lpf_step;
			sub_reg     <= sub_reg + sub_step;
		end
	end

	// Three reduced-rate stages: decimated sample, harmonic, scaled harmonic.
	always_ff @(posedge clk) begin
		if (reset) begin
			dec_s1_reg      <= '0;
			env_reg         <= '0;
			harm_s2_reg     <= '0;
			harm_s3_reg     <= '0;
			interp_prev_reg <= '0;
		end else if (dsp_tick) begin
			dec_s1_reg      <= lpf_reg + lpf_step;
			env_reg         <= env_reg + env_step;
			harm_s2_reg     <= harm_next;
			harm_s3_reg     <= scaled_cut;
			interp_prev_reg <= harm_s3_reg;
		end
	end

	bhec_fifo #(
		.WIDTH (3 * W),
		.DEPTH (FIFO_DEPTH)
	) u_out_fifo (
		.clk       (clk),
		.reset     (reset),
		.in_data   ({wr_sub, wr_right, wr_left}),
		.in_valid  (take),
		.in_ready  (fifo_ready),
		.out_data  ({out_sub, out_right, out_left}),
		.out_valid (out_valid),
		.out_ready (out_ready)
	);

	a_strap_intensity: assert property (@(posedge clk) disable iff (reset)
		release_edge |=> intensity_reg == $past(strap_level))
		else $error("intensity not taken from pins at reset exit");
	a_divider_default: assert property (@(posedge clk) disable iff (reset)
		$past(reset) |-> div_n_reg == DIVN_RESET && !sub_en_reg && div_cnt_reg == '0)
		else $error("divider or subwoofer state wrong after reset");
	a_divider_range: assert property (@(posedge clk) disable iff (reset)
		div_n_reg >= DIVN_MIN && div_n_reg <= DIVN_MAX)
		else $error("divider outside 1 to 10");
	a_effect_default: assert property (@(posedge clk) disable iff (reset)
		$past(reset) |-> !fx_off_reg && intensity_reg == INTENS_FULL)
		else $error("processing not in its normal state after reset");
	a_intensity_write: assert property (@(posedge clk) disable iff (reset)
		wr_sel_int && !release_edge |=> intensity_reg == INTENS_W'($past(reg_wdata) >> INTENS_LSB))
		else $error("intensity write not taken from the upper data bits");
	a_divider_hold: assert property (@(posedge clk) disable iff (reset)
		wr_sel_div && !wr_div_ok |=> $stable(div_n_reg))
		else $error("illegal divider value was accepted");
	// Read data stand for exactly one cycle; an idle bus must read back zero.
	a_read_idle: assert property (@(posedge clk) disable iff (reset)
		!reg_read |=> reg_rdata == '0)
		else $error("read data present without a read strobe");
	// The decimated sample equals the filter state that the same take produced.
	a_decim_frame: assert property (@(posedge clk) disable iff (reset)
		dsp_tick |=> dec_cnt_reg == '0 && dec_s1_reg == lpf_reg)
		else $error("decimation frame misaligned");
	a_harm_pipeline: assert property (@(posedge clk) disable iff (reset)
		dsp_tick |=> harm_s3_reg == $past(scaled_cut) && interp_prev_reg == $past(harm_s3_reg))
		else $error("harmonic pipeline did not advance");
	// At full intensity the scaling must be an exact identity, for either sign of the harmonic.
	a_scale_full: assert property (@(posedge clk) disable iff (reset)
		dsp_tick && intensity_reg == INTENS_FULL |=> harm_s3_reg == $past(harm_s2_reg))
		else $error("harmonic scaling wrong at full intensity");
	a_sub_disabled: assert property (@(posedge clk) disable iff (reset)
		take && !sub_en_reg |-> wr_sub == '0)
		else $error("subwoofer output active while disabled");
	a_conv_rate: assert property (@(posedge clk) disable iff (reset)
		conv_tick && div_n_reg == DIVN_MIN |-> ##1 !conv_tick [*8])
		else $error("converter slots too close together");
	a_mono_filter: assert property (@(posedge clk) disable iff (reset)
		take |=> lpf_reg == $past(lpf_reg) + (($past(left_x) + $past(right_x) - $past(lpf_reg)) >>> LP_SHIFT))
		else $error("low-pass not fed by mono sum");
	a_no_take_stalled: assert property (@(posedge clk)
		reset |=> !in_ready && !out_valid)
		else $error("sample slot or output open while in reset");
endmodule

/* File: src/bhec_fifo.sv */
`timescale 1ns/1ns
module bhec_fifo #(
	parameter int WIDTH = 48,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = PW + 1;
	localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr_reg;
	logic [PW-1:0]    rd_ptr_reg;
	logic [CW-1:0]    count_reg;
	logic [CW-1:0]    count_next;
	logic [WIDTH-1:0] out_data_reg;
	logic             out_valid_reg;
	wire              push;
	wire              pop;

	// The output register is one of the DEPTH places, so the memory stops one word short of DEPTH.
	assign in_ready   = (count_reg != FULL_COUNT);
	assign push       = in_valid && in_ready;
	assign pop        = (count_reg != '0) && (!out_valid_reg || out_ready);
	assign count_next = count_reg + (push ? CW'(1) : CW'(0)) - (pop ? CW'(1) : CW'(0));
	assign out_data   = out_data_reg;
	assign out_valid  = out_valid_reg;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			wr_ptr_reg    <= '0;
			rd_ptr_reg    <= '0;
			count_reg     <= '0;
			out_valid_reg <= 1'b0;
			out_data_reg  <= '0;
		end else begin
			count_reg <= count_next;
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + PW'(1);
			end
			if (pop) begin
				rd_ptr_reg    <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + PW'(1);
				out_data_reg  <= mem[rd_ptr_reg];
				out_valid_reg <= 1'b1;
			end else if (out_ready) begin
				out_valid_reg <= 1'b0;
			end
		end
	end

	a_fifo_full_stall: assert property (@(posedge clk) disable iff (reset)
		!in_ready |-> out_valid && count_reg == FULL_COUNT)
		else $error("fifo refused data while not full");
	a_fifo_hold_out: assert property (@(posedge clk) disable iff (reset)
		out_valid && !out_ready |=> out_valid && $stable(out_data))
		else $error("fifo output changed while stalled");
endmodule

/* File: src/bhec_pkg.sv */
package bhec_pkg;
	localparam int SAMPLE_W        = 16;
	localparam int ADDR_W          = 4;
	localparam int DATA_W          = 8;
	localparam int FIFO_DEPTH      = 16;
	localparam int CONV_DIV        = 256;
	localparam int DECIM           = 64;
	localparam int DECIM_W         = 6;
	localparam int HARM_LATENCY    = 3;
	localparam int LP_SHIFT        = 6;
	localparam int SUB_SHIFT       = LP_SHIFT - 1;
	localparam int ENV_SHIFT       = 2;
	localparam int DIVN_W          = 4;
	localparam int DIVCNT_W        = 12;
	localparam int INTENS_W        = 6;
	localparam int CLK_PERIOD_NS   = 40;

	localparam logic [ADDR_W-1:0] REG_CTRL      = 4'h0;
	localparam logic [ADDR_W-1:0] REG_INTENSITY = 4'h1;
	localparam logic [ADDR_W-1:0] REG_DIVIDER   = 4'h2;
	localparam logic [ADDR_W-1:0] REG_STATUS    = 4'h3;

	localparam int CTRL_OFF_BIT    = 7;
	localparam int CTRL_SUB_BIT    = 3;
	localparam int INTENS_LSB      = 2;
	localparam int DIVN_LSB        = 4;
	localparam int STAT_INRDY_BIT  = 0;
	localparam int STAT_OUTV_BIT   = 1;
	localparam int STAT_PHASE_LSB  = 2;

	localparam logic [INTENS_W-1:0] INTENS_FULL  = 6'h3f;
	localparam logic [INTENS_W-1:0] INTENS_3Q    = 6'h2f;
	localparam logic [INTENS_W-1:0] INTENS_HALF  = 6'h1f;
	localparam logic [DIVN_W-1:0]   DIVN_RESET   = 4'h1;
	localparam logic [DIVN_W-1:0]   DIVN_MIN     = 4'h1;
	localparam logic [DIVN_W-1:0]   DIVN_MAX     = 4'ha;
	localparam logic [DECIM_W-1:0]  DECIM_LAST   = 6'h3f;
	localparam logic [DIVCNT_W-1:0] DIVCNT_CONV  = 12'hff;
endpackage

/* File: test/bhec_core_bench.sv */
`timescale 1ns/1ns
module bhec_core_bench;
	import bhec_pkg::*;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic [3:0]  reg_addr = 4'h0;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_write = 1'b0;
	logic        reg_read = 1'b0;
	logic [7:0]  reg_rdata;
	logic        sda_in = 1'b1;
	logic        scl_in = 1'b1;
	logic [15:0] left_val = 16'h0000;
	logic [15:0] right_val = 16'h0000;
	logic        stall = 1'b0;
	logic [15:0] in_left, in_right, out_left, out_right, out_sub;
	logic        in_valid, in_ready, out_valid, out_ready;
	logic [15:0] v;
	logic [5:0]  strap_lvl [4] = '{INTENS_FULL, INTENS_HALF, INTENS_3Q, INTENS_FULL};
	int          fails = 0;
	int          checks = 0;
	int          k;
	int          n;

	bhec_core dut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .sda_in(sda_in), .scl_in(scl_in), .in_left(in_left),
		.in_right(in_right), .in_valid(in_valid), .in_ready(in_ready), .out_left(out_left),
		.out_right(out_right), .out_sub(out_sub), .out_valid(out_valid), .out_ready(out_ready));
	bhec_source src (.clk(clk), .reset(reset), .left_val(left_val), .right_val(right_val), .stall(stall),
		.in_ready(in_ready), .in_left(in_left), .in_right(in_right), .in_valid(in_valid), .out_ready(out_ready));

	initial forever #(CLK_PERIOD_NS / 2) clk = ~clk;

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic timeout();
		fails++;
		$display("Error at %0t: wait ran out", $time);
		summarize();
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe, so they are taken there.
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		#1 d = {8'h00, reg_rdata};
		@(posedge clk);
	endtask
	// Straps are set sixteen cycles ahead of release, well past the synchroniser depth.
	task automatic do_reset(input logic s, input logic c);
		sda_in <= s;
		scl_in <= c;
		reset <= 1'b1;
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wait_ready();
		for (int i = 0; i < 3000; i++) begin
			@(posedge clk);
			#1 if (in_ready === 1'b1) return;
		end
		timeout();
	endtask
	task automatic next_out();
		for (int i = 0; i < 3000; i++) begin
			@(posedge clk);
			#1 if (out_valid === 1'b1) return;
		end
		timeout();
	endtask
	task automatic t_reset_values();
		for (int i = 0; i < 4; i++) begin
			do_reset(i[1], i[0]);
			rd(REG_INTENSITY, v);
			check(v, {8'h00, strap_lvl[i], 2'b00});
		end
		do_reset(1'b1, 1'b1);
		rd(REG_INTENSITY, v);
		check(v, 16'h00fc);
		rd(REG_CTRL, v);
		check(v, 16'h0000);
		rd(REG_DIVIDER, v);
		check(v, 16'h0010);
		rd(4'hf, v);
		check(v, 16'h0000);
		$display("reset values done");
	endtask
	task automatic t_regs();
		wr(REG_INTENSITY, 8'hbc);
		rd(REG_INTENSITY, v);
		check(v, 16'h00bc);
		wr(REG_DIVIDER, 8'ha0);
		rd(REG_DIVIDER, v);
		check(v, 16'h00a0);
		wr(REG_DIVIDER, 8'hb0);
		wr(REG_DIVIDER, 8'h00);
		rd(REG_DIVIDER, v);
		check(v, 16'h00a0);
		wr(REG_DIVIDER, 8'h10);
		$display("register access done");
	endtask
	// The second interval is measured so that a divider change mid-count does not matter.
	task automatic t_rate(input int dn);
		wr(REG_DIVIDER, {dn[3:0], 4'h0});
		wait_ready();
		wait_ready();
		for (k = 1; k <= 3000; k++) begin
			@(posedge clk);
			#1 if (in_ready === 1'b1) break;
		end
		if (k > 3000) timeout();
		check(16'(k), 16'(dn * CONV_DIV));
		wr(REG_DIVIDER, 8'h10);
		$display("slot rate done");
	endtask
	task automatic t_paths();
		wr(REG_CTRL, 8'h80);
		left_val <= 16'h1234;
		right_val <= 16'h0567;
		repeat (3) next_out();
		check(out_left, 16'h1234);
		check(out_right, 16'h0567);
		wr(REG_CTRL, 8'h00);
		left_val <= 16'h0400;
		right_val <= 16'h0100;
		repeat (3) next_out();
		check(out_left - out_right, 16'h0300);
		check(out_sub, 16'h0000);
		wr(REG_CTRL, 8'h08);
		repeat (3) next_out();
		check({15'h0000, out_sub !== 16'h0000}, 16'h0001);
		wr(REG_CTRL, 8'h00);
		$display("signal paths done");
	endtask
	task automatic t_fifo();
		stall <= 1'b1;
		n = 0;
		repeat (18 * CONV_DIV) begin
			@(posedge clk);
			#1 if (in_ready === 1'b1 && in_valid === 1'b1) n++;
		end
		check(16'(n), 16'(FIFO_DEPTH));
		rd(REG_STATUS, v);
		check(v[1:0], 16'h0002);
		stall <= 1'b0;
		n = 0;
		for (int i = 0; i < 100; i++) begin
			@(posedge clk);
			#1 if (out_valid === 1'b1 && out_ready === 1'b1) n++;
			if (out_valid !== 1'b1 && out_ready === 1'b1) break;
		end
		check(16'(n), 16'(FIFO_DEPTH));
		rd(REG_STATUS, v);
		check(v[0], 16'h0001);
		$display("buffer done");
	endtask
	// 140 takes after a fresh reset span two reduced-rate frames at full intensity.
	task automatic t_harm();
		do_reset(1'b1, 1'b1);
		left_val <= 16'h2000;
		right_val <= 16'h2000;
		repeat (140) next_out();
		check(out_left - out_right, 16'h0000);
		rd(REG_STATUS, v);
		check(v, 16'h0031);
		$display("harmonic path done");
	endtask

	initial begin
		t_reset_values();
		t_regs();
		t_rate(1);
		t_rate(2);
		t_paths();
		t_fifo();
		t_harm();
		summarize();
	end
endmodule

/* File: test/bhec_source.sv */
`timescale 1ns/1ns
module bhec_source (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic [15:0] left_val,
	input  wire logic [15:0] right_val,
	input  wire logic        stall,
	input  wire logic        in_ready,
	output logic      [15:0] in_left,
	output logic      [15:0] in_right,
	output logic             in_valid,
	output logic             out_ready
);
	// A sample is held until taken, so a skipped slot never loses the value.
	always @(posedge clk) begin
		if (reset) begin
			in_valid <= 1'b0;
			in_left <= 16'h0000;
			in_right <= 16'h0000;
		end else if (!in_valid || in_ready) begin
			in_valid <= 1'b1;
			in_left <= left_val;
			in_right <= right_val;
		end
		out_ready <= !stall;
	end
endmodule
